// ==== design/fpp_sequencer.sv ====
`default_nettype none
module fpp_sequencer #(
    parameter int unsigned ERASE_CYCLES = fpp_pkg::ERASE_CYC,
    parameter int unsigned PROG_CYCLES = fpp_pkg::PROG_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    output logic so_out,
    output logic so_oe_n_out,
    output logic rdy_out,
    output logic status_rdy_out,
    output logic arr_erase_out,
    output logic arr_wr_out,
    output logic [fpp_pkg::PAGE_W-1:0] arr_page_out,
    output logic [fpp_pkg::BUF_AW-1:0] arr_col_out,
    output logic [7:0] arr_data_out
);
    import fpp_pkg::*;

    function automatic logic op_buf2(input logic [7:0] op);
        op_buf2 = (op == OP_PRG_ERS_B2) || (op == OP_PRG_NOE_B2) ||
                  (op == OP_MAIN_PRG_B2) || (op == OP_BUF_WR_B2) ||
                  (op == OP_BUF_RD_B2);
    endfunction

    function automatic logic op_erases(input logic [7:0] op);
        op_erases = (op == OP_PRG_ERS_B1) || (op == OP_PRG_ERS_B2) ||
                    (op == OP_MAIN_PRG_B1) || (op == OP_MAIN_PRG_B2);
    endfunction

    function automatic logic op_launches(input logic [7:0] op);
        op_launches = op_erases(op) || (op == OP_PRG_NOE_B1) ||
                      (op == OP_PRG_NOE_B2);
    endfunction

    function automatic logic op_data_in(input logic [7:0] op);
        op_data_in = (op == OP_MAIN_PRG_B1) || (op == OP_MAIN_PRG_B2) ||
                     (op == OP_BUF_WR_B1) || (op == OP_BUF_WR_B2);
    endfunction

    function automatic logic op_read(input logic [7:0] op);
        op_read = (op == OP_BUF_RD_B1) || (op == OP_BUF_RD_B2);
    endfunction

    // pins cross into the system clock; serial clock edges are found here
    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;

    fpp_pin_sync #(
        .W(3),
        .RST_VAL(PIN_RST)
    ) u_sync (
        .clk_in(clk_sys_in),
        .rst_in(rst_in),
        .pins_in({cs_n_in, sck_in, si_in}),
        .level_out(pin_lvl),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    wire logic cs_n_s = pin_lvl[2];
    wire logic cs_fall = pin_fall[2];
    wire logic cs_rise = pin_rise[2];
    wire logic si_s = pin_lvl[0];
    wire logic sck_take = pin_rise[1] & ~cs_n_s;
    wire logic sck_give = pin_fall[1] & ~cs_n_s;

    // serial front end
    logic [5:0] bitcnt;
    logic [31:0] shreg;
    logic [7:0] op;
    logic hdr_done;
    logic [2:0] dbit;
    logic [7:0] dbyte;
    logic [8:0] ptr;
    logic [PAGE_W-1:0] page_hdr;

    wire logic [31:0] next_shreg = {shreg[30:0], si_s};
    wire logic [7:0] next_dbyte = {dbyte[6:0], si_s};
    wire logic [5:0] hdr_len = op_read(op) ? RD_HDR_BITS : HDR_BITS;
    wire logic hdr_end = sck_take & ~hdr_done & (bitcnt == hdr_len - 6'h01);
    wire logic is_rd = op_read(op);
    wire logic is_din = op_data_in(op);
    wire logic sel_buf = op_buf2(op);
    wire logic [8:0] next_ptr = (ptr == BUF_LAST) ? 9'h000 : ptr + 9'h001;
    wire logic byte_in = sck_take & hdr_done & is_din & (dbit == 3'h7);
    wire logic byte_out = sck_give & hdr_done & is_rd & (dbit == 3'h7);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in || cs_fall) begin
            bitcnt <= '0;
            hdr_done <= 1'b0;
            dbit <= '0;
        end else if (sck_take && !hdr_done) begin
            bitcnt <= bitcnt + 6'h01;
            hdr_done <= hdr_end;
        end else if ((sck_take && is_din) || (sck_give && is_rd)) begin
            if (hdr_done) begin
                dbit <= dbit + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            shreg <= '0;
            op <= '0;
            dbyte <= '0;
            ptr <= '0;
            page_hdr <= '0;
        end else if (sck_take && !hdr_done) begin
            shreg <= next_shreg;
            if (bitcnt == OPC_LAST_BIT) begin
                op <= next_shreg[7:0];
            end
            if (hdr_end) begin
                page_hdr <= next_shreg[PAGE_LSB +: PAGE_W];
                ptr <= is_rd ? next_shreg[RD_COL_LSB +: BUF_AW]
                             : next_shreg[COL_LSB +: BUF_AW];
            end
        end else if (sck_take && hdr_done && is_din) begin
            dbyte <= next_dbyte;
            if (byte_in) begin
                ptr <= next_ptr;
            end
        end else if (byte_out) begin
            ptr <= next_ptr;
        end
    end

    // self-timed sequencer
    fpp_seq_t state;
    logic [CNT_W-1:0] cnt;
    logic seq_buf;
    logic [PAGE_W-1:0] seq_page;

    wire logic busy = (state != SQ_IDLE);
    // the 82h/85h header alone also completes; data bytes are optional
    wire logic launch = cs_rise & hdr_done & op_launches(op) &
                        ~busy;
    wire logic erase_end = (state == SQ_ERASE) &&
                           (cnt == CNT_W'(ERASE_CYCLES - 1));
    wire logic prog_end = (state == SQ_PROG) &&
                          (cnt == CNT_W'(PROG_CYCLES - 1));
    wire fpp_seq_t launch_state = op_erases(op) ? SQ_ERASE : SQ_PROG;
    wire fpp_seq_t next_state =
        launch ? launch_state :
        erase_end ? SQ_PROG :
        prog_end ? SQ_IDLE : state;
    wire logic [CNT_W-1:0] next_cnt =
        (launch || erase_end || prog_end) ? '0 :
        busy ? cnt + CNT_W'(1) : cnt;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state <= SQ_IDLE;
            cnt <= '0;
            seq_buf <= 1'b0;
            seq_page <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            if (launch) begin
                seq_buf <= sel_buf;
                seq_page <= page_hdr;
            end
        end
    end

    // buffers; the busy one refuses serial writes, the other stays open
    wire logic prog_active = (state == SQ_PROG) &&
                             (cnt < CNT_W'(BUF_BYTES));
    wire logic [BUF_AW-1:0] prog_addr = cnt[BUF_AW-1:0];
    wire logic buf_blocked = busy && (seq_buf == sel_buf);
    logic [1:0] wr_en;
    logic [1:0][7:0] rd_a;
    logic [1:0][7:0] rd_b;

    for (genvar g = 0; g < 2; g++) begin : g_buf
        assign wr_en[g] = byte_in && !buf_blocked && (sel_buf == 1'(g));
        fpp_page_buffer #(
            .DEPTH(BUF_BYTES),
            .AW(BUF_AW)
        ) u_buf (
            .clk_in(clk_sys_in),
            .wr_en_in(wr_en[g]),
            .wr_addr_in(ptr),
            .wr_data_in(next_dbyte),
            .rd_a_addr_in(ptr),
            .rd_a_data_out(rd_a[g]),
            .rd_b_addr_in(prog_addr),
            .rd_b_data_out(rd_b[g])
        );
    end

    // buffer bytes go out unchanged, so all ones leave an erased page
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            arr_wr_out <= 1'b0;
            arr_col_out <= '0;
        end else begin
            arr_wr_out <= prog_active;
            arr_col_out <= prog_addr;
        end
    end

    assign arr_data_out = rd_b[seq_buf];
    assign arr_page_out = seq_page;
    assign arr_erase_out = (state == SQ_ERASE);
    assign rdy_out = ~busy;
    assign status_rdy_out = ~busy;

    // serial read of a buffer, bits change on the falling serial clock
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            so_out <= 1'b0;
            so_oe_n_out <= 1'b1;
        end else begin
            so_oe_n_out <= ~(hdr_done & is_rd & ~cs_n_s);
            if (sck_give && hdr_done && is_rd) begin
                so_out <= rd_a[sel_buf][3'h7 - dbit];
            end
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    sequence s_erase_phase;
        arr_erase_out [*8];
    endsequence

    sequence s_wr_burst;
        arr_wr_out [*8];
    endsequence

    a_launch_busy: assert property (
        launch |=> !rdy_out && !status_rdy_out)
        else $error("launch did not raise busy");
    a_stay_ready: assert property (
        rdy_out && !launch |=> rdy_out)
        else $error("busy without a select rising edge");
    a_erase_first: assert property (
        launch && op_erases(op) |=> s_erase_phase ##0 !arr_wr_out)
        else $error("erase phase missing before program");
    a_noerase_skip: assert property (
        launch && !op_erases(op) |=> (!arr_erase_out) [*8])
        else $error("program-only operation erased");
    a_erase_len: assert property (
        $fell(arr_erase_out) |-> $past(cnt) == CNT_W'(ERASE_CYCLES - 1))
        else $error("erase phase length wrong");
    a_write_span: assert property (
        arr_wr_out |-> !arr_erase_out && arr_col_out <= BUF_LAST)
        else $error("array write outside program phase");
    a_ptr_wrap: assert property (
        byte_in && ptr == BUF_LAST |=> ptr == 9'h000)
        else $error("buffer pointer did not wrap");
    a_other_buf: assert property (
        busy && |wr_en |-> !wr_en[seq_buf])
        else $error("busy buffer was written");
    a_hdr_len: assert property (
        $rose(hdr_done) |-> $past(bitcnt) == hdr_len - 6'h01)
        else $error("header length wrong");
    a_page_latch: assert property (
        launch |=> arr_page_out == $past(page_hdr))
        else $error("page address not captured");
    a_refuse_busy: assert property (
        busy && cs_rise |=> arr_page_out == $past(arr_page_out))
        else $error("command accepted while busy");
    a_prog_len: assert property (
        $rose(rdy_out) |-> $past(cnt) == CNT_W'(PROG_CYCLES - 1))
        else $error("program phase length wrong");
    a_wr_first: assert property (
        $rose(arr_wr_out) |-> arr_col_out == 9'h000)
        else $error("page copy did not start at byte zero");
    a_wr_last: assert property (
        $fell(arr_wr_out) |-> $past(arr_col_out) == BUF_LAST)
        else $error("page copy did not cover the whole buffer");
    a_wr_burst: assert property (
        $rose(arr_wr_out) |-> s_wr_burst)
        else $error("page copy not on consecutive cycles");
endmodule // fpp_sequencer
`default_nettype wire

// ==== design/fpp_pkg.sv ====
`default_nettype none
package fpp_pkg;
    // opcodes, buffer 1 / buffer 2
    localparam logic [7:0] OP_PRG_ERS_B1 = 8'h83;
    localparam logic [7:0] OP_PRG_ERS_B2 = 8'h86;
    localparam logic [7:0] OP_PRG_NOE_B1 = 8'h88;
    localparam logic [7:0] OP_PRG_NOE_B2 = 8'h89;
    localparam logic [7:0] OP_MAIN_PRG_B1 = 8'h82;
    localparam logic [7:0] OP_MAIN_PRG_B2 = 8'h85;
    localparam logic [7:0] OP_BUF_WR_B1 = 8'h84;
    localparam logic [7:0] OP_BUF_WR_B2 = 8'h87;
    localparam logic [7:0] OP_BUF_RD_B1 = 8'h54;
    localparam logic [7:0] OP_BUF_RD_B2 = 8'h56;

    localparam int BUF_BYTES = 264;
    localparam int BUF_AW = 9;
    localparam int PAGE_W = 11;
    localparam logic [8:0] BUF_LAST = 9'h107;

    // header lengths in bits, opcode included
    localparam logic [5:0] HDR_BITS = 6'h20;
    localparam logic [5:0] RD_HDR_BITS = 6'h28;
    localparam logic [5:0] OPC_LAST_BIT = 6'h07;
    // field positions inside the shifted header
    localparam int PAGE_LSB = 9;
    localparam int COL_LSB = 0;
    localparam int RD_COL_LSB = 8;

    // self-timed operation, program-only is 70% of erase plus program
    localparam int CLK_MHZ = 25;
    localparam int T_ERASE_US = 600;
    localparam int T_PROG_US = 1400;
    localparam int ERASE_CYC = T_ERASE_US * CLK_MHZ;
    localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
    localparam int CNT_W = 17;

    localparam logic [2:0] PIN_RST = 3'h4;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_ERASE = 2'b01,
        SQ_PROG = 2'b10
    } fpp_seq_t;
endpackage
`default_nettype wire

// ==== design/fpp_pin_sync.sv ====
`default_nettype none
module fpp_pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] pins_in,
    output logic [W-1:0] level_out,
    output logic [W-1:0] rise_out,
    output logic [W-1:0] fall_out
);
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta <= RST_VAL;
            sync <= RST_VAL;
            prev <= RST_VAL;
        end else begin
            meta <= pins_in;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level_out = sync;
    assign rise_out = sync & ~prev;
    assign fall_out = ~sync & prev;
endmodule // fpp_pin_sync
`default_nettype wire

// ==== design/fpp_page_buffer.sv ====
`default_nettype none
module fpp_page_buffer #(
    parameter int DEPTH = 264,
    parameter int AW = 9
) (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [AW-1:0] rd_a_addr_in,
    output logic [7:0] rd_a_data_out,
    input wire logic [AW-1:0] rd_b_addr_in,
    output logic [7:0] rd_b_data_out
);
    // no reset: unwritten bytes keep old contents
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_a_data_out <= mem[rd_a_addr_in];
        rd_b_data_out <= mem[rd_b_addr_in];
    end
endmodule // fpp_page_buffer
`default_nettype wire

// ==== testbench/fpp_host_model.sv ====
`default_nettype none
module fpp_host_model (
    input wire logic clk_in,
    input wire logic so_in,
    input wire logic so_oe_n_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic si_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // select stays low over header and data
    task automatic frame_open();
        wait_clk(1);
        cs_n_out = 1'b0;
        wait_clk(4);
    endtask
    task automatic frame_close();
        wait_clk(4);
        cs_n_out = 1'b1;
        // released line: never leave the last bit showing
        si_out = ~si_out;
        wait_clk(8);
    endtask
    // msb first, one bit per serial clock, 320 ns period
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_out = tx[i];
            wait_clk(4);
            rx[i] = so_oe_n_in ? 1'bx : so_in;
            sck_out = 1'b1;
            wait_clk(4);
            sck_out = 1'b0;
        end
    endtask
endmodule // fpp_host_model
`default_nettype wire

// ==== testbench/tb.sv ====
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fpp_pkg::*;
    // 3:7 split keeps program-only at 70% of erase plus program
    localparam int E = 900;
    localparam int P = 2100;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic cs_n, sck, si, so_out, so_oe_n_out, rdy_out, status_rdy_out;
    logic arr_erase_out, arr_wr_out;
    logic [10:0] arr_page_out, got_page;
    logic [8:0] arr_col_out;
    logic [7:0] arr_data_out;
    logic [7:0] eb [2][BUF_BYTES];
    logic [7:0] got [BUF_BYTES];
    int n_errors = 0, n_compared = 0;
    int n_busy, n_ers, n_wr, ers_at_wr;
    always #20 clk_sys_in = ~clk_sys_in;
    fpp_sequencer #(.ERASE_CYCLES(E), .PROG_CYCLES(P)) fpp_sequencer_i (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n),
        .sck_in(sck), .si_in(si), .so_out(so_out),
        .so_oe_n_out(so_oe_n_out), .rdy_out(rdy_out),
        .status_rdy_out(status_rdy_out), .arr_erase_out(arr_erase_out),
        .arr_wr_out(arr_wr_out), .arr_page_out(arr_page_out),
        .arr_col_out(arr_col_out), .arr_data_out(arr_data_out));
    fpp_host_model fpp_host_model_i (
        .clk_in(clk_sys_in), .so_in(so_out), .so_oe_n_in(so_oe_n_out),
        .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // sampled mid-cycle, away from the edge that launches the outputs
    always @(negedge clk_sys_in) begin
        if (!rst_in) begin
            chk(status_rdy_out, rdy_out);
            if (!rdy_out) n_busy++;
            if (arr_erase_out) n_ers++;
            if (arr_wr_out) begin
                chk(arr_col_out, n_wr[8:0]);
                if (n_wr == 0) ers_at_wr = n_ers;
                got[arr_col_out] = arr_data_out;
                got_page = arr_page_out;
                n_wr++;
            end
        end
    end
    task automatic tx(input logic [7:0] b);
        logic [7:0] r;
        fpp_host_model_i.xfer(b, r);
    endtask
    // reserved header bits always sent as zero
    task automatic hdr(input logic [7:0] op, input logic [23:0] rest);
        tx(op);
        tx(rest[23:16]);
        tx(rest[15:8]);
        tx(rest[7:0]);
    endtask
    // data bytes land at successive positions, wrapping
    task automatic fill(input int b, input int c, input int n,
        input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            eb[b][c] = base + 8'(i * 7);
            tx(eb[b][c]);
            c = (c == BUF_BYTES - 1) ? 0 : c + 1;
        end
    endtask
    task automatic buf_write(input int b, input logic [8:0] col,
        input int n, input logic [7:0] base);
        fpp_host_model_i.frame_open();
        hdr(b ? OP_BUF_WR_B2 : OP_BUF_WR_B1, {15'h0, col});
        fill(b, col, n, base);
        fpp_host_model_i.frame_close();
    endtask
    task automatic buf_read(input int b, input int c, input int n);
        logic [7:0] r;
        fpp_host_model_i.frame_open();
        hdr(b ? OP_BUF_RD_B2 : OP_BUF_RD_B1, {15'h0, 9'(c)});
        tx(8'h00);
        for (int i = 0; i < n; i++) begin
            fpp_host_model_i.xfer(8'h00, r);
            chk(r, eb[b][c]);
            c = (c == BUF_BYTES - 1) ? 0 : c + 1;
        end
        fpp_host_model_i.frame_close();
    endtask
    task automatic wait_rdy(input logic lvl, input int lim);
        int k;
        k = 0;
        while (rdy_out !== lvl && k < lim) begin
            @(negedge clk_sys_in);
            k++;
        end
        chk(rdy_out, lvl);
    endtask
    task automatic launch(input logic [7:0] op, input int b,
        input logic [10:0] pg, input logic [8:0] col, input int n);
        n_busy = 0;
        n_ers = 0;
        n_wr = 0;
        ers_at_wr = 0;
        fpp_host_model_i.frame_open();
        hdr(op, {4'h0, pg, col});
        fill(b, col, n, 8'h5C);
        fpp_host_model_i.frame_close();
        wait_rdy(1'b0, 20);
    endtask
    task automatic finish(input int b, input logic [10:0] pg, input bit ers);
        wait_rdy(1'b1, E + P + 100);
        chk(n_busy, ers ? E + P : (E + P) * 7 / 10);
        chk(n_ers, ers ? E : 0);
        chk(ers_at_wr, ers ? E : 0);
        chk(n_wr, BUF_BYTES);
        chk(got_page, pg);
        for (int i = 0; i < BUF_BYTES; i++) chk(got[i], eb[b][i]);
    endtask
    task automatic prog(input logic [7:0] op, input int b,
        input logic [10:0] pg, input logic [8:0] col, input int n,
        input bit ers);
        launch(op, b, pg, col, n);
        finish(b, pg, ers);
    endtask
    // other buffer stays usable while one programs
    task automatic t_overlap();
        launch(OP_PRG_ERS_B2, 1, 11'h2C1, 9'h000, 0);
        buf_write(0, 9'h102, 10, 8'hA0);
        buf_read(0, 258, 10);
        chk(rdy_out, 1'b0);
        // a program command while busy must be dropped
        fpp_host_model_i.frame_open();
        hdr(OP_PRG_NOE_B1, {4'h0, 11'h055, 9'h000});
        fpp_host_model_i.frame_close();
        finish(1, 11'h2C1, 1'b1);
    endtask
    // header cut short: select rise must not launch anything
    task automatic t_short();
        n_busy = 0;
        n_wr = 0;
        fpp_host_model_i.frame_open();
        tx(OP_PRG_ERS_B1);
        tx(8'h00);
        tx(8'h00);
        fpp_host_model_i.frame_close();
        fpp_host_model_i.wait_clk(40);
        chk(n_busy, 0);
        chk(n_wr, 0);
    endtask
    initial begin
        // a clean run takes about 3 ms
        #3600us;
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (16) @(negedge clk_sys_in);
        rst_in = 1'b0;
        fpp_host_model_i.wait_clk(4);
        buf_write(1, 9'h005, BUF_BYTES, 8'h11);
        buf_read(1, 262, 4);
        buf_write(0, 9'h000, BUF_BYTES, 8'h00);
        for (int i = 0; i < BUF_BYTES; i++) eb[0][i] = 8'hFF;
        buf_write(0, 9'h000, 0, 8'h00);
        fpp_host_model_i.frame_open();
        hdr(OP_BUF_WR_B1, 24'h0);
        for (int i = 0; i < BUF_BYTES; i++) tx(8'hFF);
        fpp_host_model_i.frame_close();
        prog(OP_PRG_ERS_B1, 0, 11'h7A5, 9'h000, 0, 1'b1);
        prog(OP_PRG_ERS_B1, 0, 11'h013, 9'h000, 0, 1'b1);
        prog(OP_PRG_NOE_B2, 1, 11'h7A5, 9'h000, 0, 1'b0);
        t_overlap();
        prog(OP_PRG_NOE_B1, 0, 11'h013, 9'h000, 0, 1'b0);
        prog(OP_MAIN_PRG_B1, 0, 11'h003, 9'h105, 6, 1'b1);
        prog(OP_MAIN_PRG_B2, 1, 11'h400, 9'h000, 3, 1'b1);
        t_short();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
